// ### rtl/seq_params.svh
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// program side
`define SEQ_PC_W 9
`define SEQ_PC_RESET 9'h000
`define SEQ_PC_ONE 9'h001
`define SEQ_ROM_WORDS 512
`define SEQ_ROM_LAST 9'h1ff
`define SEQ_ROM_DATA_W 16

// data memory organisation
`define SEQ_DADDR_W 7
`define SEQ_NIBBLE_W 4
`define SEQ_RAM_WORDS 128
`define SEQ_ROW_GEN_REG 3'h0

// port registers
`define SEQ_PORT_NUM 4
`define SEQ_PORT_IDX_W 2
`define SEQ_ADDR_PORT_BASE 7'h70

// cpu control area
`define SEQ_ADDR_ZERO_LO 7'h74
`define SEQ_ADDR_ZERO_HI 7'h7d
`define SEQ_ADDR_BCD 7'h7e
`define SEQ_ADDR_PSW 7'h7f
`define SEQ_BIT_BCD 0
`define SEQ_BIT_CMP 3
`define SEQ_BIT_CY 2
`define SEQ_BIT_Z 1
`define SEQ_FLAGS_RESET 1'h0
`define SEQ_NIBBLE_ZERO 4'h0

`endif

// ### rtl/seq_pkg.sv
`default_nettype none
`include "seq_params.svh"

package seq_pkg;

  // instruction class as decoded outside this block
  typedef enum logic [3:0] {
    op_idle,
    op_jump,
    op_invoke,
    op_leave,
    op_arith,
    op_logic,
    op_skip_cmp,
    op_skip_bit,
    op_transfer
  } op_e;

  // source of a pending data memory read
  typedef enum logic [2:0] {
    src_ram,
    src_port,
    src_zero,
    src_bcd,
    src_psw
  } rd_src_e;

  typedef struct packed {
    logic [`SEQ_PC_W-1:0] pc;
    logic [`SEQ_PC_W-1:0] stack;
    logic skip;
    logic bcd;
    logic cmp;
    logic cy;
    logic z;
    logic [`SEQ_PORT_NUM*`SEQ_NIBBLE_W-1:0] port_out;
    logic [`SEQ_PORT_NUM-1:0] port_oe;
    logic [`SEQ_PORT_NUM*`SEQ_NIBBLE_W-1:0] pin_meta;
    logic [`SEQ_PORT_NUM*`SEQ_NIBBLE_W-1:0] pin_sync;
    logic rd_pend;
    rd_src_e rd_src;
    logic [`SEQ_PORT_IDX_W-1:0] rd_port;
    logic rd_valid;
    logic [`SEQ_NIBBLE_W-1:0] rd_data;
  } seq_state_s;

endpackage

`default_nettype wire

// ### rtl/nibble_mem_if.sv
`default_nettype none
`include "seq_params.svh"

// carrier between the sequencer and its nibble store
interface nibble_mem_if;
  logic we;
  logic [`SEQ_DADDR_W-1:0] waddr;
  logic [`SEQ_NIBBLE_W-1:0] wdata;
  logic re;
  logic [`SEQ_DADDR_W-1:0] raddr;
  logic [`SEQ_NIBBLE_W-1:0] rdata;

  modport user (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

`default_nettype wire

// ### rtl/nibble_ram.sv
`default_nettype none
`include "seq_params.svh"

module nibble_ram #(
  parameter int WORDS = `SEQ_RAM_WORDS
) (
  // clock
  input wire logic clk,
  // access
  nibble_mem_if.mem bus
);

  logic [`SEQ_NIBBLE_W-1:0] mem_q [WORDS];
  logic [`SEQ_NIBBLE_W-1:0] rdata_q;

  // contents are not cleared by reset, as in the real array
  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
    if (bus.re) begin
      rdata_q <= mem_q[bus.raddr]; // read before write on a collision
    end
  end

  assign bus.rdata = rdata_q;

endmodule

`default_nettype wire

// ### rtl/cpu_sequencer_and_status.sv
// Functional notes
// [RQ1] instruction pointer is a nine bit binary counter
// [RQ2] each executed instruction advances the pointer by one
// [RQ3] jump, invoke and leave load the target address into the pointer; leave here loads the saved stack address instead
// [RQ4] after a skip the next address is fetched; a taken skip idles it
// [RQ5] one entry return stack: invoke saves, leave restores the address
// [RQ6] reset clears the pointer so execution starts at address zero
// [RQ7] program memory holds 512 words of 16 bits, one instruction each
// [RQ8] data memory is nibble wide; upper three bits row, lower four column
// [RQ9] row zero is the general register because the row pointer is zero
// [RQ10] writing a port register turns the port to output until reset
// [RQ11] reading a port register returns pin levels in either mode
// [RQ12] decimal flag at 7E bit 0; compare, carry, zero at 7F bits 3..1
// [RQ13] upper three bits of 7E and bit 0 of 7F always zero
// [RQ14] compare skips keep carry; arithmetic updates carry even in compare mode
// [RQ15] reset clears every status flag
// [RQ16] compare clear: zero result sets zero flag, non-zero clears it
// [RQ17] compare set: zero result keeps zero flag, non-zero clears it
// [RQ18] a bit test skip clears the compare flag
// [RQ19] locations 74 to 7D read zero and ignore writes
`default_nettype none
`include "seq_params.svh"

module cpu_sequencer_and_status (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // instruction execution
  input wire logic exec,
  input wire seq_pkg::op_e op,
  input wire logic [`SEQ_PC_W-1:0] target_addr,
  input wire logic skip_cond,
  input wire logic [`SEQ_NIBBLE_W-1:0] alu_result,
  input wire logic alu_carry,
  // data memory access
  input wire logic [`SEQ_DADDR_W-1:0] mem_addr,
  input wire logic use_gen_reg,
  input wire logic mem_wr,
  input wire logic [`SEQ_NIBBLE_W-1:0] mem_wdata,
  input wire logic mem_rd,
  // sequencing state
  output logic [`SEQ_PC_W-1:0] instr_pointer,
  output logic [`SEQ_PC_W-1:0] return_addr,
  output logic skip_active,
  // read answer
  output logic [`SEQ_NIBBLE_W-1:0] rd_data,
  output logic rd_valid,
  // status flags
  output logic decimal_adjust_flag,
  output logic compare_accumulate_flag,
  output logic carry_flag,
  output logic result_null_flag,
  // port pins
  input wire logic [`SEQ_PORT_NUM*`SEQ_NIBBLE_W-1:0] port_pins_in,
  output logic [`SEQ_PORT_NUM*`SEQ_NIBBLE_W-1:0] port_pins_out,
  output logic [`SEQ_PORT_NUM-1:0] port_pins_oe
);

  localparam int NW = `SEQ_NIBBLE_W;
  localparam int PN = `SEQ_PORT_NUM;
  // a literal cannot be part-selected, so the port base gets a typed copy
  localparam logic [`SEQ_DADDR_W-1:0] PORT_BASE = `SEQ_ADDR_PORT_BASE;

  seq_pkg::seq_state_s s_q;
  seq_pkg::seq_state_s s_d;

  nibble_mem_if ram_bus ();

  // general purpose nibbles only; the port and control area words of the array stay unused
  nibble_ram #(
    .WORDS(`SEQ_RAM_WORDS)
  ) u_ram (
    .clk(clk),
    .bus(ram_bus)
  );

  // decoded view of the current instruction
  logic live;
  logic [`SEQ_DADDR_W-1:0] eff_addr;
  logic hit_port;
  logic hit_zero;
  logic hit_bcd;
  logic hit_psw;
  logic hit_ram;
  logic [`SEQ_PORT_IDX_W-1:0] port_idx;
  logic [`SEQ_PC_W-1:0] pc_inc;

  // a suppressed instruction does nothing but advance the pointer
  assign live = exec && !s_q.skip; // [RQ4]
  assign pc_inc = s_q.pc + `SEQ_PC_ONE; // [RQ1] [RQ2]

  // row zero addressing for the general register operand
  always_comb begin
    if (use_gen_reg) begin
      eff_addr = {`SEQ_ROW_GEN_REG, mem_addr[3:0]}; // [RQ8] [RQ9]
    end else begin
      eff_addr = mem_addr; // [RQ8]
    end
  end

  // address map of the nibble space
  assign hit_port = (eff_addr[`SEQ_DADDR_W-1:`SEQ_PORT_IDX_W]
                     == PORT_BASE[`SEQ_DADDR_W-1:`SEQ_PORT_IDX_W]); // [RQ10] [RQ11]
  assign hit_zero = (eff_addr >= `SEQ_ADDR_ZERO_LO) && (eff_addr <= `SEQ_ADDR_ZERO_HI); // [RQ19]
  assign hit_bcd = (eff_addr == `SEQ_ADDR_BCD);
  assign hit_psw = (eff_addr == `SEQ_ADDR_PSW);
  assign hit_ram = !hit_port && !hit_zero && !hit_bcd && !hit_psw;
  assign port_idx = eff_addr[`SEQ_PORT_IDX_W-1:0];

  // only plain data nibbles reach the array; the rest live in flops
  always_comb begin
    ram_bus.we = live && mem_wr && hit_ram;
    ram_bus.waddr = eff_addr;
    ram_bus.wdata = mem_wdata;
    ram_bus.re = live && mem_rd && hit_ram;
    ram_bus.raddr = eff_addr;
  end

  // next state
  always_comb begin
    s_d = s_q;

    // pins pass two flops before anything looks at them
    s_d.pin_meta = port_pins_in;
    s_d.pin_sync = s_q.pin_meta;

    // sequencing
    if (exec) begin
      s_d.pc = pc_inc; // [RQ2]
      s_d.skip = 1'b0; // [RQ4]
      if (live) begin
        case (op)
          seq_pkg::op_jump: begin
            s_d.pc = target_addr; // [RQ3]
          end
          seq_pkg::op_invoke: begin
            s_d.stack = pc_inc; // [RQ5]
            s_d.pc = target_addr; // [RQ3]
          end
          seq_pkg::op_leave: begin
            s_d.pc = s_q.stack; // [RQ3] [RQ5]
          end
          seq_pkg::op_skip_cmp: begin
            s_d.skip = skip_cond; // [RQ4]
          end
          seq_pkg::op_skip_bit: begin
            s_d.skip = skip_cond; // [RQ4]
          end
          default: begin
            s_d.pc = pc_inc;
          end
        endcase
      end
    end

    // status flags from the instruction itself
    if (live) begin
      case (op)
        seq_pkg::op_arith: begin
          s_d.cy = alu_carry; // [RQ14]
          if (!s_q.cmp) begin
            s_d.z = (alu_result == `SEQ_NIBBLE_ZERO); // [RQ16]
          end else if (alu_result != `SEQ_NIBBLE_ZERO) begin
            s_d.z = 1'b0; // [RQ17]
          end
        end
        seq_pkg::op_skip_bit: begin
          s_d.cmp = 1'b0; // [RQ18]
        end
        seq_pkg::op_skip_cmp: begin
          s_d.cy = s_q.cy; // [RQ14]
        end
        default: begin
          s_d.cy = s_d.cy;
        end
      endcase
    end

    // explicit stores land after the flag update, so the store wins
    if (live && mem_wr) begin
      if (hit_bcd) begin
        s_d.bcd = mem_wdata[`SEQ_BIT_BCD]; // [RQ12] [RQ13]
      end
      if (hit_psw) begin
        s_d.cmp = mem_wdata[`SEQ_BIT_CMP]; // [RQ12]
        s_d.cy = mem_wdata[`SEQ_BIT_CY]; // [RQ12]
        s_d.z = mem_wdata[`SEQ_BIT_Z]; // [RQ12] [RQ13]
      end
      for (int i = 0; i < PN; i++) begin
        if (hit_port && (port_idx == `SEQ_PORT_IDX_W'(i))) begin
          s_d.port_out[i*NW +: NW] = mem_wdata; // [RQ10]
          s_d.port_oe[i] = 1'b1; // [RQ10]
        end
      end
    end

    // read pipeline: request, select, answer
    s_d.rd_pend = live && mem_rd;
    s_d.rd_valid = s_q.rd_pend;
    if (live && mem_rd) begin
      s_d.rd_port = port_idx;
      if (hit_port) begin
        s_d.rd_src = seq_pkg::src_port;
      end else if (hit_zero) begin
        s_d.rd_src = seq_pkg::src_zero;
      end else if (hit_bcd) begin
        s_d.rd_src = seq_pkg::src_bcd;
      end else if (hit_psw) begin
        s_d.rd_src = seq_pkg::src_psw;
      end else begin
        s_d.rd_src = seq_pkg::src_ram;
      end
    end
    if (s_q.rd_pend) begin
      case (s_q.rd_src)
        seq_pkg::src_port: begin
          s_d.rd_data = s_q.pin_sync[s_q.rd_port*NW +: NW]; // [RQ11]
        end
        seq_pkg::src_zero: begin
          s_d.rd_data = `SEQ_NIBBLE_ZERO; // [RQ19]
        end
        seq_pkg::src_bcd: begin
          s_d.rd_data = {3'h0, s_q.bcd}; // [RQ12] [RQ13]
        end
        seq_pkg::src_psw: begin
          s_d.rd_data = {s_q.cmp, s_q.cy, s_q.z, 1'b0}; // [RQ12] [RQ13]
        end
        default: begin
          s_d.rd_data = ram_bus.rdata;
        end
      endcase
    end
  end

  // one register for the whole block; reset starts at address zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0; // [RQ6] [RQ15]
    end else begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register
  assign instr_pointer = s_q.pc; // [RQ7]
  assign return_addr = s_q.stack;
  assign skip_active = s_q.skip;
  assign rd_data = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;
  assign decimal_adjust_flag = s_q.bcd;
  assign compare_accumulate_flag = s_q.cmp;
  assign carry_flag = s_q.cy;
  assign result_null_flag = s_q.z;
  assign port_pins_out = s_q.port_out;
  assign port_pins_oe = s_q.port_oe;

endmodule

`default_nettype wire

// ### testbench/seq_monitor.sv
`default_nettype none
module seq_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // instruction side
  input wire logic exec,
  input wire seq_pkg::op_e op,
  input wire logic [8:0] target_addr,
  input wire logic skip_cond,
  input wire logic [3:0] alu_result,
  input wire logic alu_carry,
  input wire logic [6:0] mem_addr,
  input wire logic use_gen_reg,
  input wire logic mem_wr,
  input wire logic mem_rd,
  // observed state
  input wire logic [8:0] instr_pointer,
  input wire logic [8:0] return_addr,
  input wire logic skip_active,
  input wire logic rd_valid,
  input wire logic compare_accumulate_flag,
  input wire logic carry_flag,
  input wire logic result_null_flag,
  input wire logic [3:0] port_pins_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // an instruction that is not idled by a pending skip
  wire logic go = exec && !skip_active;
  sequence rd_req;
    go && mem_rd;
  endsequence
  sequence skip_armed;
    go && (op == seq_pkg::op_skip_cmp || op == seq_pkg::op_skip_bit) && skip_cond ##1 exec;
  endsequence
  a_step_by_one: assert property (
    go && !(op inside {seq_pkg::op_jump, seq_pkg::op_invoke, seq_pkg::op_leave})
    |=> instr_pointer == 9'($past(instr_pointer) + 9'h001)) else $error("pointer did not advance");
  a_idle_after_skip: assert property (
    skip_armed |=> !skip_active && instr_pointer == 9'($past(instr_pointer) + 9'h001) && $stable(carry_flag))
    else $error("skipped instruction not idled");
  a_jump_load: assert property (
    go && (op == seq_pkg::op_jump || op == seq_pkg::op_invoke) |=> instr_pointer == $past(target_addr))
    else $error("target not loaded");
  a_stack_save: assert property (
    go && op == seq_pkg::op_invoke |=> return_addr == 9'($past(instr_pointer) + 9'h001))
    else $error("return address not saved");
  a_stack_restore: assert property (
    go && op == seq_pkg::op_leave |=> instr_pointer == $past(return_addr)) else $error("return not restored");
  a_carry_hold: assert property (
    go && op == seq_pkg::op_skip_cmp && !mem_wr |=> $stable(carry_flag)) else $error("compare moved carry");
  // stores to the flag nibble override the arithmetic update, so they are left out
  a_zero_rule: assert property (
    go && op == seq_pkg::op_arith && !mem_wr |=> carry_flag == $past(alu_carry) && result_null_flag ==
    ($past(alu_result) != 4'h0 ? 1'b0 : $past(compare_accumulate_flag) ? $past(result_null_flag) : 1'b1))
    else $error("arithmetic flags wrong");
  a_cmp_clear: assert property (
    go && op == seq_pkg::op_skip_bit && !mem_wr |=> !compare_accumulate_flag) else $error("compare flag kept");
  a_read_latency: assert property (
    rd_req |-> ##2 rd_valid) else $error("read answer late");
  a_port_output: assert property (
    go && mem_wr && !use_gen_reg && mem_addr[6:2] == 5'h1c |=> port_pins_oe[$past(mem_addr[1:0])])
    else $error("port not in output mode");
  a_oe_sticky: assert property (
    (~port_pins_oe & $past(port_pins_oe)) == 4'h0) else $error("port left output mode");
endmodule

bind cpu_sequencer_and_status seq_monitor mon (.clk, .rstn, .exec, .op, .target_addr, .skip_cond, .alu_result,
  .alu_carry, .mem_addr, .use_gen_reg, .mem_wr, .mem_rd, .instr_pointer, .return_addr, .skip_active, .rd_valid,
  .compare_accumulate_flag, .carry_flag, .result_null_flag, .port_pins_oe);
`default_nettype wire

// ### testbench/cpu_sequencer_and_status_bench.sv
`default_nettype none
module cpu_sequencer_and_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
  logic clk = 0, rstn = 0, exec = 0, skip_cond = 0, alu_carry = 0, use_gen_reg = 0, mem_wr = 0, mem_rd = 0;
  seq_pkg::op_e op = seq_pkg::op_idle;
  logic [8:0] target_addr = 9'h000, instr_pointer, return_addr;
  logic [3:0] alu_result = 4'h0, mem_wdata = 4'h0, rd_data, port_pins_oe;
  logic [6:0] mem_addr = 7'h00;
  // pins held still so the two flop sampler has settled long before any port read
  logic [15:0] port_pins_in = 16'hc3a6, port_pins_out;
  logic skip_active, rd_valid, decimal_adjust_flag, compare_accumulate_flag, carry_flag, result_null_flag;
  int n_errors = 0, checks_done = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  cpu_sequencer_and_status dut (.clk, .rstn, .exec, .op, .target_addr, .skip_cond, .alu_result, .alu_carry,
    .mem_addr, .use_gen_reg, .mem_wr, .mem_wdata, .mem_rd, .instr_pointer, .return_addr, .skip_active, .rd_data,
    .rd_valid, .decimal_adjust_flag, .compare_accumulate_flag, .carry_flag, .result_null_flag, .port_pins_in,
    .port_pins_out, .port_pins_oe);
  // one instruction per call; calls in a row execute back to back
  task ex(input seq_pkg::op_e o, input logic [8:0] t, input logic s, input logic [3:0] r, input logic c);
    @(posedge clk);
    op <= o;
    {exec, target_addr, skip_cond, alu_result, alu_carry, mem_wr, mem_rd} <= {1'b1, t, s, r, c, 2'b00};
  endtask
  task mw(input logic [6:0] a, input logic [3:0] d);
    @(posedge clk);
    op <= seq_pkg::op_transfer;
    {exec, mem_wr, mem_rd, mem_addr, mem_wdata} <= {1'b1, 2'b10, a, d};
  endtask
  // let the last instruction land, then settle
  task done;
    @(posedge clk);
    {exec, mem_wr, mem_rd} <= 3'b000;
    #1;
  endtask
  task rdc(input logic [6:0] a, input logic [3:0] e);
    int i;
    @(posedge clk);
    op <= seq_pkg::op_transfer;
    {exec, mem_wr, mem_rd, mem_addr} <= {1'b1, 2'b01, a};
    done;
    for (i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (rd_valid !== 1'b1) begin
      n_errors++;
      stop_test;
    end
    `CHK(rd_data, e)
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) rstn <= 1'b1;
    `CHK({instr_pointer, port_pins_oe, compare_accumulate_flag, carry_flag, result_null_flag}, 16'h0)
    repeat (3) ex(seq_pkg::op_idle, 0, 0, 0, 0);
    done;
    `CHK(instr_pointer, 9'h003)
    ex(seq_pkg::op_jump, 9'h1ff, 0, 0, 0);
    ex(seq_pkg::op_idle, 0, 0, 0, 0);
    done;
    `CHK(instr_pointer, 9'h000)
    ex(seq_pkg::op_jump, 9'h0a0, 0, 0, 0);
    ex(seq_pkg::op_invoke, 9'h155, 0, 0, 0);
    done;
    `CHK({instr_pointer, return_addr}, {9'h155, 9'h0a1})
    ex(seq_pkg::op_leave, 0, 0, 0, 0);
    done;
    `CHK(instr_pointer, 9'h0a1)
    // a taken skip must swallow the arithmetic effects of the next instruction
    ex(seq_pkg::op_skip_cmp, 0, 1, 0, 0);
    ex(seq_pkg::op_arith, 0, 0, 4'h0, 1);
    done;
    `CHK({instr_pointer, skip_active, carry_flag, result_null_flag}, {9'h0a3, 3'b000})
    ex(seq_pkg::op_arith, 0, 0, 4'h0, 1);
    done;
    `CHK({carry_flag, result_null_flag}, 2'b11)
    mw(7'h7f, 4'ha);
    ex(seq_pkg::op_arith, 0, 0, 4'h0, 0);
    done;
    `CHK({compare_accumulate_flag, carry_flag, result_null_flag}, 3'b101)
    ex(seq_pkg::op_arith, 0, 0, 4'h3, 1);
    ex(seq_pkg::op_arith, 0, 0, 4'h0, 1);
    ex(seq_pkg::op_skip_cmp, 0, 0, 0, 0);
    done;
    `CHK({compare_accumulate_flag, carry_flag, result_null_flag}, 3'b110)
    rdc(7'h7f, 4'hc);
    ex(seq_pkg::op_skip_bit, 0, 0, 0, 0);
    done;
    `CHK(compare_accumulate_flag, 1'b0)
    mw(7'h7e, 4'hf);
    mw(7'h7f, 4'hf);
    rdc(7'h7e, 4'h1);
    rdc(7'h7f, 4'he);
    mw(7'h05, 4'h9);
    mw(7'h25, 4'h3);
    done;
    @(posedge clk) use_gen_reg <= 1'b1;
    rdc(7'h35, 4'h9);
    @(posedge clk) use_gen_reg <= 1'b0;
    rdc(7'h25, 4'h3);
    for (int a = 'h74; a <= 'h7d; a++) begin
      mw(7'(a), 4'hf);
      rdc(7'(a), 4'h0);
    end
    rdc(7'h70, 4'h6);
    mw(7'h71, 4'h5);
    done;
    `CHK({port_pins_oe, port_pins_out[7:4]}, 8'h25)
    rdc(7'h71, 4'ha);
    // second reset drops the port back to input mode
    @(negedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk) rstn <= 1'b1;
    `CHK({port_pins_oe, instr_pointer}, 13'h0)
    stop_test;
  end
endmodule
`default_nettype wire
